/* File: rtl/tcd_decoder.sv */
// module: device end, captures the command byte and drives per-counter actions
// Overview of operation
// - host writes one byte; device latches it
// - low five bits select counters, bit0 counter1
// - toggle/step commands carry index 1 to 5
// - top bits zero load element and group pointer
// - top bits pick arm, load, save, disarm ops
// - prefixes set/clear toggle or step one counter
// - fixed codes set or clear single mode bits
// - F8/F9 prefetch on/off, FF master reset
// - host never writes the unused codes
// - arm touches only selected counters
// - counting needs armed, then gating qualifies it
// - disarm at terminal count waits until leaving
// - arm resets alternating selector to hold first
// - load copies chosen source, sources unchanged
// - load one before terminal count enters it
// - load at terminal count ends it, keeps selector
// - disarmed load at terminal count uses load register unless gate-selected
// - gate-selected modes: gate level picks load source
// - load-made terminal count flips the selector, except by load-and-arm
// - reload during terminal count never flips selector
// - host avoids load-and-arm when asynchronous
// - step counts one either way, even disarmed
// - save copies live count into hold register
`timescale 1ns/1ps
module tcd_decoder
   import tcd_pkg::*;
(
   input wire logic CLK,
   input wire logic RST,
   tcd_if.device BUS,
   input wire logic [4:0] TC_STATE,
   input wire logic [4:0] AT_PRE_TC,
   input wire logic [4:0] SRC_EDGE,
   input wire logic [4:0] GATE_LEVEL,
   input wire logic [4:0] MODE_ALT,
   input wire logic [4:0] MODE_GATESEL,
   output logic [7:0] COMMAND_ENTRY,
   output logic [4:0] ARMED,
   output logic [4:0] COUNT_ENABLE,
   output logic [4:0] LOAD_PULSE,
   output logic [4:0] LOAD_SRC,
   output logic [4:0] SAVE_PULSE,
   output logic [4:0] STEP_PULSE,
   output logic [4:0] TOGGLE,
   output logic [4:0] ALT_SEL,
   output logic [1:0] ELEMENT,
   output logic [2:0] GROUP,
   output logic BYTE_PTR_SET,
   output logic POINTER_SEQUENCING_DISABLE,
   output logic FREQ_OUT_GATE_OFF,
   output logic WIDE_BUS_SELECT,
   output logic PREFETCH_EN,
   output logic MASTER_RESET
);
   typedef struct packed {
      logic [7:0] cmd;
      logic [4:0] armed;
      logic [4:0] pend_dis;
      logic [4:0] cnt_en;
      logic [4:0] load;
      logic [4:0] lsrc;
      logic [4:0] save;
      logic [4:0] step;
      logic [4:0] tog;
      logic [4:0] alt;
      logic [1:0] elem;
      logic [2:0] grp;
      logic bptr;
      logic seq_dis;
      logic frequency_output_off;
      logic bus16;
      logic pf;
      logic mrst;
   } tcd_state_t;

   tcd_state_t r;
   tcd_state_t next_r;
   logic [4:0] idx_hot;
   logic idx_ok;
   logic [4:0] sel;
   logic [2:0] op;
   logic [4:0] pfx;
   logic wr;

   assign wr = BUS.cmd_write;
   assign sel = BUS.cmd_data[TCD_SEL_W-1:0];
   assign op = BUS.cmd_data[TCD_OP_MSB:TCD_OP_LSB];
   assign pfx = BUS.cmd_data[7:3];

   // index decode for single-counter commands
   tcd_index_decode u_idx (
      .idx(BUS.cmd_data[TCD_IDX_W-1:0]),
      .onehot(idx_hot),
      .valid(idx_ok)
   );

   // command decode; one struct copy holds every next value
   always_comb begin
      logic [4:0] ld;
      logic [4:0] leave_tc;
      next_r = r;
      ld = 5'h00;
      leave_tc = 5'h00;
      next_r.load = 5'h00;
      next_r.save = 5'h00;
      next_r.step = 5'h00;
      next_r.bptr = 1'b0;
      next_r.mrst = 1'b0;
      if (wr) begin
         next_r.cmd = BUS.cmd_data;
         unique case (op)
            TCD_OP_PTR: begin
               // reserved groups ignored so pointer stays defined
               if (BUS.cmd_data[TCD_GRP_MSB:0] != TCD_GRP_BAD0 &&
                   BUS.cmd_data[TCD_GRP_MSB:0] != TCD_GRP_BAD6) begin
                  next_r.elem = BUS.cmd_data[TCD_ELEM_MSB:TCD_ELEM_LSB];
                  next_r.grp = BUS.cmd_data[TCD_GRP_MSB:0];
                  next_r.bptr = 1'b1;
               end
            end
            TCD_OP_ARM: begin
               next_r.armed = r.armed | sel;
               next_r.pend_dis = r.pend_dis & ~sel;
               next_r.alt = r.alt & ~sel;
            end
            TCD_OP_LOAD: ld = sel;
            TCD_OP_LDARM: begin
               ld = sel;
               next_r.armed = r.armed | sel;
               next_r.pend_dis = r.pend_dis & ~sel; // arm part cancels a held disarm
               next_r.alt = r.alt & ~sel;
            end
            TCD_OP_DISSAVE, TCD_OP_DISARM: begin
               // counters in terminal count leave it before disarm lands
               next_r.armed = r.armed & ~(sel & ~TC_STATE);
               next_r.pend_dis = r.pend_dis | (sel & TC_STATE);
               if (op == TCD_OP_DISSAVE) begin
                  next_r.save = sel;
               end
            end
            TCD_OP_SAVE: next_r.save = sel;
            TCD_OP_MISC: begin
               if (pfx == TCD_PFX_TOG_SET && idx_ok) begin
                  next_r.tog = r.tog | idx_hot;
               end else if (pfx == TCD_PFX_TOG_CLR && idx_ok) begin
                  next_r.tog = r.tog & ~idx_hot;
               end else if (pfx == TCD_PFX_STEP && idx_ok) begin
                  next_r.step = idx_hot;
               end
               // fixed codes override the index reading of E6/E7/EE/EF
               unique case (BUS.cmd_data)
                  TCD_C_SEQ_DIS: next_r.seq_dis = 1'b1;
                  TCD_C_SEQ_EN: next_r.seq_dis = 1'b0;
                  TCD_C_FREQUENCY_OUTPUT_OFF: begin
                     next_r.frequency_output_off = 1'b1;
                     next_r.tog = r.tog;
                  end
                  TCD_C_FREQUENCY_OUTPUT_ON: begin
                     next_r.frequency_output_off = 1'b0;
                     next_r.tog = r.tog;
                  end
                  TCD_C_BUS16: begin
                     next_r.bus16 = 1'b1;
                     next_r.tog = r.tog;
                  end
                  TCD_C_BUS8: begin
                     next_r.bus16 = 1'b0;
                     next_r.tog = r.tog;
                  end
                  TCD_C_PF_EN: next_r.pf = 1'b1;
                  TCD_C_PF_DIS: next_r.pf = 1'b0;
                  TCD_C_MRESET: next_r.mrst = 1'b1;
                  default: ; // unused codes fall through unchanged
               endcase
            end
         endcase
      end
      // load source: gate level, else load register when disarmed in tc, else due source
      for (int i = 0; i < TCD_NCNT; i++) begin
         if (MODE_GATESEL[i]) begin
            next_r.lsrc[i] = GATE_LEVEL[i];
         end else if (TC_STATE[i] && !r.armed[i]) begin
            next_r.lsrc[i] = TCD_SRC_LOAD;
         end else if (MODE_ALT[i]) begin
            next_r.lsrc[i] = ~r.alt[i] ? TCD_SRC_HOLD : TCD_SRC_LOAD;
         end else begin
            next_r.lsrc[i] = TCD_SRC_LOAD;
         end
      end
      next_r.load = ld;
      // pseudo-count into terminal count flips selector; reload in tc does not
      // load-and-arm leaves the selector reset: its arm part wins over the flip
      next_r.alt = next_r.alt ^ (ld & AT_PRE_TC & ~TC_STATE & MODE_ALT &
                                 ~{5{op == TCD_OP_LDARM}});
      // any count, load or step ends terminal count and releases a held disarm
      leave_tc = TC_STATE & (SRC_EDGE | ld | next_r.step);
      // held disarm lands as tc is left; load-and-arm has already cleared it
      next_r.armed = next_r.armed & ~(next_r.pend_dis & leave_tc);
      next_r.pend_dis = next_r.pend_dis & ~leave_tc;
      next_r.cnt_en = next_r.armed;
      if (r.mrst) begin
         next_r = '0;
         next_r.grp = TCD_RST_GRP;
      end
   end

   // single register stage for all state
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         r <= '0;
         r.armed <= TCD_RST_ARMED;
         r.tog <= TCD_RST_TOGGLE;
         r.alt <= TCD_RST_ALT;
         r.elem <= TCD_RST_ELEM;
         r.grp <= TCD_RST_GRP;
         r.pf <= TCD_RST_PREFETCH;
         r.seq_dis <= TCD_RST_MODEBIT;
      end else begin
         r <= next_r;
      end
   end

   assign COMMAND_ENTRY = r.cmd;
   assign ARMED = r.armed;
   assign COUNT_ENABLE = r.cnt_en;
   assign LOAD_PULSE = r.load;
   assign LOAD_SRC = r.lsrc;
   assign SAVE_PULSE = r.save;
   assign STEP_PULSE = r.step;
   assign TOGGLE = r.tog;
   assign ALT_SEL = r.alt;
   assign ELEMENT = r.elem;
   assign GROUP = r.grp;
   assign BYTE_PTR_SET = r.bptr;
   assign POINTER_SEQUENCING_DISABLE = r.seq_dis;
   assign FREQ_OUT_GATE_OFF = r.frequency_output_off;
   assign WIDE_BUS_SELECT = r.bus16;
   assign PREFETCH_EN = r.pf;
   assign MASTER_RESET = r.mrst;
endmodule : tcd_decoder

/* File: rtl/tcd_pkg.sv */
// package: command codes, field positions and reset values of the timer command decoder
package tcd_pkg;
   localparam int TCD_NCNT = 5;
   localparam int TCD_CMD_W = 8;
   // opcode field (top three bits)
   localparam int TCD_OP_MSB = 7;
   localparam int TCD_OP_LSB = 5;
   localparam logic [2:0] TCD_OP_PTR = 3'h0;
   localparam logic [2:0] TCD_OP_ARM = 3'h1;
   localparam logic [2:0] TCD_OP_LOAD = 3'h2;
   localparam logic [2:0] TCD_OP_LDARM = 3'h3;
   localparam logic [2:0] TCD_OP_DISSAVE = 3'h4;
   localparam logic [2:0] TCD_OP_SAVE = 3'h5;
   localparam logic [2:0] TCD_OP_DISARM = 3'h6;
   localparam logic [2:0] TCD_OP_MISC = 3'h7;
   // five-bit prefixes for single counter commands and the special F8-FF group
   localparam logic [4:0] TCD_PFX_TOG_CLR = 5'h1C;
   localparam logic [4:0] TCD_PFX_TOG_SET = 5'h1D;
   localparam logic [4:0] TCD_PFX_STEP = 5'h1E;
   localparam logic [4:0] TCD_PFX_SPECIAL = 5'h1F;
   // fixed codes
   localparam logic [7:0] TCD_C_SEQ_DIS = 8'hE8;
   localparam logic [7:0] TCD_C_SEQ_EN = 8'hE0;
   localparam logic [7:0] TCD_C_FREQUENCY_OUTPUT_OFF = 8'hEE;
   localparam logic [7:0] TCD_C_FREQUENCY_OUTPUT_ON = 8'hE6;
   localparam logic [7:0] TCD_C_BUS16 = 8'hEF;
   localparam logic [7:0] TCD_C_BUS8 = 8'hE7;
   localparam logic [7:0] TCD_C_PF_EN = 8'hF8;
   localparam logic [7:0] TCD_C_PF_DIS = 8'hF9;
   localparam logic [7:0] TCD_C_MRESET = 8'hFF;
   // select mask / index / pointer fields
   localparam int TCD_SEL_W = 5;
   localparam int TCD_IDX_W = 3;
   localparam int TCD_ELEM_MSB = 4;
   localparam int TCD_ELEM_LSB = 3;
   localparam int TCD_GRP_MSB = 2;
   localparam logic [2:0] TCD_GRP_BAD0 = 3'h0;
   localparam logic [2:0] TCD_GRP_BAD6 = 3'h6;
   localparam logic [2:0] TCD_IDX_MIN = 3'h1;
   localparam logic [2:0] TCD_IDX_MAX = 3'h5;
   // reset values
   localparam logic [4:0] TCD_RST_ARMED = 5'h00;
   localparam logic [4:0] TCD_RST_TOGGLE = 5'h00;
   localparam logic [4:0] TCD_RST_ALT = 5'h00;
   localparam logic [1:0] TCD_RST_ELEM = 2'h0;
   localparam logic [2:0] TCD_RST_GRP = 3'h1;
   localparam logic TCD_RST_PREFETCH = 1'b0;
   localparam logic TCD_RST_MODEBIT = 1'b0;
   // reload source encodings
   localparam logic TCD_SRC_LOAD = 1'b0;
   localparam logic TCD_SRC_HOLD = 1'b1;
   // host-side register offsets
   localparam logic [7:0] TCD_REG_CMD = 8'h00;
   localparam logic [7:0] TCD_REG_STAT = 8'h04;
endpackage : tcd_pkg

/* File: rtl/tcd_if.sv */
// interface: control-port byte strobe between the host and the command decoder
`timescale 1ns/1ps
interface tcd_if;
   logic cmd_write;
   logic [7:0] cmd_data;
   modport host (output cmd_write, output cmd_data);
   modport device (input cmd_write, input cmd_data);
endinterface : tcd_if

/* File: rtl/tcd_index_decode.sv */
// module: turns a three-bit counter index into a one-hot counter select
`timescale 1ns/1ps
module tcd_index_decode
   import tcd_pkg::*;
(
   input wire logic [2:0] idx,
   output logic [4:0] onehot,
   output logic valid
);
   // only indices one to five name a counter; the rest select nothing
   always_comb begin
      valid = (idx >= TCD_IDX_MIN) && (idx <= TCD_IDX_MAX);
      onehot = 5'h00;
      if (valid) begin
         onehot = 5'(5'h01 << (idx - TCD_IDX_MIN));
      end
   end
endmodule : tcd_index_decode

/* File: rtl/tcd_host.sv */
// module: host end, AHB-Lite slave that forwards command bytes to the control port
`timescale 1ns/1ps
module tcd_host
   import tcd_pkg::*;
(
   input wire logic CLK,
   input wire logic RST,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   output logic [7:0] BLOCKED_COUNT,
   tcd_if.host BUS
);
   typedef struct packed {
      logic ph_wr;
      logic [7:0] ph_addr;
      logic strobe;
      logic [7:0] data;
      logic [7:0] last;
      logic [7:0] blocked;
      logic [31:0] rdata;
   } tcd_host_t;

   tcd_host_t r;
   tcd_host_t next_r;

   // unused codes per the device map; the host refuses them
   function automatic logic tcd_unused(input logic [7:0] c);
      logic u;
      u = 1'b0;
      if (c[7:5] == TCD_OP_PTR &&
          (c[2:0] == TCD_GRP_BAD0 || c[2:0] == TCD_GRP_BAD6)) u = 1'b1;
      if (c[7:3] == TCD_PFX_SPECIAL && c != TCD_C_PF_EN && c != TCD_C_PF_DIS &&
          c != TCD_C_MRESET) u = 1'b1;
      if (c[7:3] == TCD_PFX_STEP && (c[2:0] == 3'h0 || c[2:0] > TCD_IDX_MAX)) u = 1'b1;
      return u;
   endfunction : tcd_unused

   // address phase capture and one-cycle command strobe
   always_comb begin
      next_r = r;
      next_r.strobe = 1'b0;
      next_r.ph_wr = 1'b0;
      if (HSEL && HREADY && HTRANS[1]) begin
         next_r.ph_wr = HWRITE;
         next_r.ph_addr = HADDR[7:0];
         next_r.rdata = (HADDR[7:0] == TCD_REG_CMD) ? {24'h000000, r.last} :
                        (HADDR[7:0] == TCD_REG_STAT) ? {24'h000000, r.blocked} : 32'h00000000;
      end
      if (r.ph_wr && r.ph_addr == TCD_REG_CMD) begin
         if (tcd_unused(HWDATA[7:0])) begin
            next_r.blocked = 8'(r.blocked + 8'h01);
         end else begin
            next_r.strobe = 1'b1;
            next_r.data = HWDATA[7:0];
            next_r.last = HWDATA[7:0];
         end
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign HRDATA = r.rdata;
   assign HREADYOUT = 1'b1;
   assign HRESP = 1'b0;
   assign BLOCKED_COUNT = r.blocked;
   assign BUS.cmd_write = r.strobe;
   assign BUS.cmd_data = r.data;
endmodule : tcd_host

/* File: sim/tcd_props.sv */
// checker: relations between the command strobe and the decoder outputs
`timescale 1ns/1ps
module tcd_props
   import tcd_pkg::*;
(
   input wire logic CLK,
   input wire logic RST,
   input wire logic cmd_write,
   input wire logic [7:0] cmd_data,
   input wire logic [4:0] TC_STATE,
   input wire logic [7:0] COMMAND_ENTRY,
   input wire logic [4:0] ARMED,
   input wire logic [4:0] LOAD_PULSE,
   input wire logic [4:0] SAVE_PULSE,
   input wire logic [4:0] STEP_PULSE,
   input wire logic [4:0] TOGGLE,
   input wire logic [1:0] ELEMENT,
   input wire logic [2:0] GROUP,
   input wire logic WIDE_BUS_SELECT,
   input wire logic PREFETCH_EN,
   input wire logic MASTER_RESET
);
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   // index one-hot, only meaningful for indices 1..5
   logic [4:0] oh;
   logic [2:0] op;
   logic idx_ok;
   assign oh = 5'h01 << (cmd_data[2:0] - 3'h1);
   assign op = cmd_data[7:5];
   assign idx_ok = cmd_data[2:0] >= TCD_IDX_MIN && cmd_data[2:0] <= TCD_IDX_MAX;
   cap_entry_a: assert property (
      cmd_write && cmd_data != TCD_C_MRESET |=> COMMAND_ENTRY == $past(cmd_data))
      else $error("command byte not captured");
   load_mask_a: assert property (
      cmd_write && (op == TCD_OP_LOAD || op == TCD_OP_LDARM)
      |=> LOAD_PULSE == $past(cmd_data[4:0])) else $error("load mask wrong");
   save_mask_a: assert property (
      cmd_write && (op == TCD_OP_SAVE || op == TCD_OP_DISSAVE)
      |=> SAVE_PULSE == $past(cmd_data[4:0])) else $error("save mask wrong");
   arm_only_a: assert property (
      cmd_write && op == TCD_OP_ARM
      |=> ARMED == ($past(ARMED) | $past(cmd_data[4:0]))) else $error("arm wrong");
   disarm_wait_a: assert property (
      cmd_write && op == TCD_OP_DISARM
      |=> ((ARMED ^ $past(ARMED)) & $past(TC_STATE) & $past(cmd_data[4:0])) == 5'h00)
      else $error("disarm in terminal count not held");
   step_one_a: assert property (
      cmd_write && cmd_data[7:3] == TCD_PFX_STEP && idx_ok
      |=> STEP_PULSE == $past(oh)) else $error("step select wrong");
   toggle_set_a: assert property (
      cmd_write && cmd_data[7:3] == TCD_PFX_TOG_SET && idx_ok
      |=> TOGGLE == ($past(TOGGLE) | $past(oh))) else $error("toggle set wrong");
   ptr_load_a: assert property (
      cmd_write && op == TCD_OP_PTR && cmd_data[2:0] != TCD_GRP_BAD0
      && cmd_data[2:0] != TCD_GRP_BAD6
      |=> {ELEMENT, GROUP} == $past(cmd_data[4:0])) else $error("pointer load wrong");
   bus_mode_a: assert property (
      cmd_write && (cmd_data == TCD_C_BUS16 || cmd_data == TCD_C_BUS8)
      |=> WIDE_BUS_SELECT == $past(cmd_data[3])) else $error("bus mode wrong");
   master_reset_a: assert property (
      cmd_write && cmd_data == TCD_C_MRESET |=> MASTER_RESET ##1
      (ARMED == TCD_RST_ARMED && !PREFETCH_EN && GROUP == TCD_RST_GRP))
      else $error("master reset wrong");
endmodule : tcd_props

/* File: sim/test_timer_command_decoder.sv */
// testbench: bus master on the host end, decoder end watched at its ports
`timescale 1ns/1ps
module test_timer_command_decoder import tcd_pkg::*;;
   logic CLK = 1'b0;
   logic RST = 1'b1;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic clr = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, r, hrd;
   logic [4:0] tc = 5'h00, pre = 5'h00, se = 5'h00, ma = 5'h00, gl = 5'h00, mg = 5'h00;
   logic [4:0] ld, sv, st, ls, arm, lp, lsrc, sp, stp, tog, alt, ce;
   logic [7:0] blk, ent;
   logic [1:0] elem;
   logic [2:0] grp;
   logic hrdy, bps, psd, fog, wbs, pfe, mrs, bp, hresp;
   int n_mismatch = 0, tests_run = 0;
   always #20 CLK = ~CLK;
   tcd_if bus ();
   tcd_host i_tcd_host (.CLK(CLK), .RST(RST), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
      .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hrdy), .HRDATA(hrd),
      .HREADYOUT(hrdy), .HRESP(hresp), .BLOCKED_COUNT(blk), .BUS(bus));
   tcd_decoder i_tcd_decoder (.CLK(CLK), .RST(RST), .BUS(bus), .TC_STATE(tc), .AT_PRE_TC(pre),
      .SRC_EDGE(se), .GATE_LEVEL(gl), .MODE_ALT(ma), .MODE_GATESEL(mg),
      .COMMAND_ENTRY(ent), .ARMED(arm), .COUNT_ENABLE(ce), .LOAD_PULSE(lp), .LOAD_SRC(lsrc),
      .SAVE_PULSE(sp), .STEP_PULSE(stp), .TOGGLE(tog), .ALT_SEL(alt), .ELEMENT(elem),
      .GROUP(grp), .BYTE_PTR_SET(bps), .POINTER_SEQUENCING_DISABLE(psd),
      .FREQ_OUT_GATE_OFF(fog), .WIDE_BUS_SELECT(wbs), .PREFETCH_EN(pfe), .MASTER_RESET(mrs));
   tcd_props i_tcd_props (.CLK(CLK), .RST(RST), .cmd_write(bus.cmd_write),
      .cmd_data(bus.cmd_data), .TC_STATE(tc), .COMMAND_ENTRY(ent), .ARMED(arm),
      .LOAD_PULSE(lp), .SAVE_PULSE(sp), .STEP_PULSE(stp), .TOGGLE(tog), .ELEMENT(elem),
      .GROUP(grp), .WIDE_BUS_SELECT(wbs), .PREFETCH_EN(pfe), .MASTER_RESET(mrs));
   // pulses last one cycle, so collect them between commands
   always @(posedge CLK) begin
      ld <= clr ? 5'h00 : ld | lp;
      sv <= clr ? 5'h00 : sv | sp;
      st <= clr ? 5'h00 : st | stp;
      ls <= clr ? 5'h00 : ls | (lsrc & lp);
      bp <= clr ? 1'b0 : bp | bps;
   end
   task automatic results;
      $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : results
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         n_mismatch++;
         $display("[FAIL] %0t seen %h expected %h", $time, s, e);
      end
   endtask : chk
   // bounded wait for ready at a rising edge
   task automatic wrdy;
      int n;
      n = 0;
      do begin
         @(posedge CLK);
         n++;
      end while (hrdy !== 1'b1 && n < 50);
      if (hrdy !== 1'b1) begin
         n_mismatch++;
         results;
      end
   endtask : wrdy
   task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
      output logic [31:0] q);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      clr <= 1'b1;
      wrdy;
      hsel <= 1'b0;
      htrans <= 2'h0;
      clr <= 1'b0;
      hwdata <= d;
      wrdy;
      q = hrd;
   endtask : ahb
   // byte reaches the decoder two edges after the data phase
   task automatic wr(input logic [7:0] c);
      ahb(1'b1, 32'h0, {24'h0, c}, r);
      repeat (3) @(posedge CLK);
   endtask : wr
   task automatic t_ptr;
      logic [7:0] b;
      b = blk;
      wr(8'h0B);
      chk({elem, grp}, 5'h0B);
      chk(bp, 1'b1);
      chk(hresp, 1'b0);
      wr(8'h06);
      chk(grp, 3'h3);
      wr(8'hF0);
      chk(blk, b + 8'h02);
      chk(ent, 8'h0B);
      ahb(1'b0, 32'h0, 32'h0, r);
      chk(r, 32'h0B);
      ahb(1'b0, 32'h4, 32'h0, r);
      chk(r, {24'h0, b + 8'h02});
      ahb(1'b0, 32'h8, 32'h0, r);
      chk(r, 32'h0);
   endtask : t_ptr
   task automatic t_arm;
      wr(8'h25);
      chk(arm, 5'h05);
      wr(8'h22);
      chk(arm, 5'h07);
      chk(ce, 5'h07);
      wr(8'hC1);
      chk(arm, 5'h06);
      wr(8'h86);
      chk({arm, sv}, 10'h006);
      wr(8'hB8);
      chk(sv, 5'h18);
      wr(8'h55);
      chk({arm, ld}, 10'h015);
      wr(8'h7F); // one clock throughout, so load-and-arm is safe here
      chk({arm, ld}, 10'h3FF);
   endtask : t_arm
   task automatic t_mode;
      logic [7:0] c [6] = '{8'hE8, 8'hEE, 8'hEF, 8'hE0, 8'hE6, 8'hE7};
      logic [2:0] e [6] = '{3'h4, 3'h6, 3'h7, 3'h3, 3'h1, 3'h0};
      for (int i = 0; i < 6; i++) begin
         wr(c[i]);
         chk({psd, fog, wbs}, e[i]);
      end
   endtask : t_mode
   task automatic t_pf;
      wr(8'hF8);
      chk(pfe, 1'b1);
      wr(8'hF9);
      chk(pfe, 1'b0);
      wr(8'hF8);
      wr(8'hFF);
      chk({pfe, arm, grp}, {1'b0, TCD_RST_ARMED, TCD_RST_GRP});
   endtask : t_pf
   // counters are disarmed here, so steps act on idle counters
   task automatic t_one;
      logic [4:0] e;
      e = 5'h00;
      for (int i = 1; i <= 5; i++) begin
         wr({TCD_PFX_STEP, 3'(i)});
         chk(st, 5'h01 << (i - 1));
         wr({TCD_PFX_TOG_SET, 3'(i)});
         e = e | (5'h01 << (i - 1));
         chk(tog, e);
      end
      wr(8'hE2);
      chk(tog, 5'h1D);
   endtask : t_one
   // alternating reload and held disarm around terminal count
   task automatic t_tc;
      ma <= 5'h01;
      pre <= 5'h01;
      wr(8'h41);
      chk(alt[0], 1'b1);
      wr(8'h21);
      chk(alt[0], 1'b0);
      wr(8'h41);
      chk({ls, alt[0]}, 6'h03);
      wr(8'h61);
      chk({ls, alt[0]}, 6'h00);
      pre <= 5'h00;
      tc <= 5'h01;
      wr(8'h41);
      chk({ld, ls, alt[0]}, 11'h042);
      wr(8'hC1);
      chk(arm[0], 1'b1);
      se <= 5'h01;
      @(posedge CLK);
      se <= 5'h00;
      repeat (2) @(posedge CLK);
      chk(arm[0], 1'b0);
   endtask : t_tc
   // counter 2 disarmed in tc, counter 3 in gate-selected reload
   task automatic t_src;
      ma <= 5'h03;
      tc <= 5'h03;
      mg <= 5'h04;
      gl <= 5'h04;
      wr(8'h46);
      chk({ld, ls}, 10'h0C4);
      gl <= 5'h00;
      wr(8'h44);
      chk({ld, ls}, 10'h080);
   endtask : t_src
   initial begin
      repeat (16) @(posedge CLK);
      RST <= 1'b0;
      @(posedge CLK);
      t_ptr;
      t_arm;
      t_mode;
      t_pf;
      t_one;
      t_tc;
      t_src;
      results;
   end
endmodule : test_timer_command_decoder
